// file: serial_flash_pin_interface_bench.sv
// Self-checking bench of the serial flash pin front end.
// Assumes sfpi_host at the pins; results matched against queued notes.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_pin_interface_bench;
  import sfpi_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_done_i = 1'b0;
  logic [7:0] arr_a = 8'h00;
  sfpi_pins_s pins;
  sfpi_drive_s drive;
  sfpi_op_s op;
  logic [7:0] arr_d, rx, rx_cnt;
  logic [7:0] seen = 8'h00;
  logic irq;
  sfpi_pwr_e pwr;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 10;
  int k = 0;
  sfpi_op_s exp_op[$];
  logic [7:0] exp_rd[$];
  logic [7:0] wd[4];
  logic [23:0] a;
  localparam logic [7:0] OPC[6] = '{CMD_PROG, CMD_ER_PAGE, CMD_ER_4K, CMD_ER_32K, CMD_ER_64K, CMD_ER_CHIP};
  localparam logic [23:0] MSK[6] = '{MASK_PAGE, MASK_PAGE, MASK_4K, MASK_32K, MASK_64K, MASK_CHIP};
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  sfpi_front sfpi_front_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .drive_o(drive),
    .op_o(op), .op_done_i(op_done_i), .arr_buf_addr_i(arr_a), .arr_buf_data_o(arr_d), .irq_o(irq), .pwr_o(pwr));
  sfpi_host sfpi_host_inst (.core_clk_i(core_clk_i), .drive_i(drive), .pins_o(pins), .rx_o(rx), .rx_cnt_o(rx_cnt));
  // ******************
  // Checking
  // ******************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Unnoted results compare against unknown and fail
  always @(posedge core_clk_i) begin
    if (op.valid === 1'b1) chk(32'(op), exp_op.size() > 0 ? 32'(exp_op.pop_front()) : 32'hX);
    if (rx_cnt !== seen) begin
      seen = rx_cnt;
      chk(32'(rx), exp_rd.size() > 0 ? 32'(exp_rd.pop_front()) : 32'hX);
    end
  end
  // ******************
  // Frames
  // ******************
  task automatic rd(input logic m3, input logic [31:0] v, input int nb, input int n, input int ln, input int dm);
    sfpi_host_inst.start(m3);
    sfpi_host_inst.send(v, nb);
    if (n > 0) sfpi_host_inst.read(n, ln, dm);
    sfpi_host_inst.stop();
  endtask
  task automatic status(input logic [7:0] e);
    exp_rd.push_back(e);
    rd(1'b0, {24'h0, CMD_STATUS}, 8, 1, 1, 0);
  endtask
  task automatic otp_wr(input logic m3, input logic [7:0] d);
    sfpi_host_inst.start(m3);
    sfpi_host_inst.send({CMD_OTP_WR, 24'h000105}, 32);
    sfpi_host_inst.send(32'(d), 8);
    sfpi_host_inst.stop();
  endtask
  initial begin
    sfpi_host_inst.cyc(4);
    rst_n_i = 1'b1;
    chk(32'(drive), 32'h0);
    chk(32'(op), 32'h0);
    chk(32'(pwr), 32'(PWR_STANDBY));
    // Status opcode while deselected: any fall taken would drive a line
    sfpi_host_inst.send({CMD_STATUS, 24'h0}, 32);
    chk(32'(pwr), 32'(PWR_STANDBY));
    chk(32'(drive), 32'h0);
    foreach (wd[k]) wd[k] = 8'($random(seed));
    sfpi_host_inst.start(1'b0);
    sfpi_host_inst.send({CMD_BUF_WR, 24'h0000FE}, 32);
    foreach (wd[k]) sfpi_host_inst.send(32'(wd[k]), 8);
    sfpi_host_inst.stop();
    // Read back across the buffer wrap on one, two and four lines
    for (int l = 1; l <= 4; l *= 2) begin
      foreach (wd[k]) exp_rd.push_back(wd[k]);
      rd(l[1], {l == 1 ? CMD_READ : l == 2 ? CMD_DUAL : CMD_QUAD, 24'h0000FE}, 32, 4, l, l == 1 ? 0 : 8);
    end
    for (int i = 0; i < 6; i++) begin
      a = 24'($random(seed));
      exp_op.push_back(sfpi_op_s'{1'b1, sfpi_op_e'(i), a & MSK[i]});
      rd(i[0], i == 5 ? {24'h0, OPC[i]} : {OPC[i], a}, i == 5 ? 8 : 32, 0, 1, 0);
      chk(32'(pwr), 32'(PWR_ACTIVE));
      if (i == 0) begin
        status(8'h01);
        rd(1'b1, {CMD_ER_4K, a}, 32, 0, 1, 0);
        k = $random(seed) & 3;
        arr_a = 8'hFE + 8'(k);
        sfpi_host_inst.cyc(2);
        chk(32'(arr_d), 32'(wd[k]));
      end
      op_done_i = 1'b1;
      sfpi_host_inst.cyc(1);
      op_done_i = 1'b0;
      sfpi_host_inst.cyc(2);
      chk(32'(irq), 32'h1);
      chk(32'(pwr), 32'(PWR_STANDBY));
      // Opcode clears the flag before the first bit goes out
      status(8'h00);
      chk(32'(irq), 32'h0);
    end
    rd(1'b0, {24'h0, CMD_DPD}, 8, 0, 1, 0);
    chk(32'(pwr), 32'(PWR_DEEP));
    rd(1'b1, {24'h0, CMD_ER_CHIP}, 8, 0, 1, 0);
    rd(1'b0, {24'h0, CMD_RESUME}, 8, 0, 1, 0);
    chk(32'(pwr), 32'(PWR_STANDBY));
    // Area 2 byte 5 written, area locked, rewrite must be lost
    otp_wr(1'b1, wd[2]);
    rd(1'b0, {CMD_OTP_LOCK, 24'h000100}, 32, 0, 1, 0);
    otp_wr(1'b0, ~wd[2]);
    exp_rd.push_back(wd[2]);
    rd(1'b1, {CMD_READ, 24'h800105}, 32, 1, 1, 0);
    sfpi_host_inst.cyc(20);
    chk(32'(exp_op.size() + exp_rd.size()), 32'h0);
    end_sim();
  end
  initial begin
    #500000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire

// file: sfpi_front.sv
// Pin-level front end of a serial flash: framing, shifting, buffer and OTP.
// Assumes the host drives select, clock and lines asynchronously to core_clk_i,
// with the link clock at most an eighth of the core clock.
`timescale 1ns/10ps
`default_nettype none
module sfpi_front (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire sfpi_pkg::sfpi_pins_s pins_i,
  output sfpi_pkg::sfpi_drive_s drive_o,
  output sfpi_pkg::sfpi_op_s op_o,
  input wire logic op_done_i,
  input wire logic [7:0] arr_buf_addr_i,
  output logic [7:0] arr_buf_data_o,
  output logic irq_o,
  output sfpi_pkg::sfpi_pwr_e pwr_o
);
  import sfpi_pkg::*;

  sfpi_state_s q;
  sfpi_state_s next_q;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [2:0] step;
  logic [7:0] src;
  logic [7:0] status;
  logic [MEM_AW-1:0] mem_ra;
  logic [MEM_DW-1:0] mem_rd;

  // ************************************************
  // Opcode helpers
  // ************************************************
  function automatic sfpi_op_e op_kind(input logic [7:0] c);
    case (c)
      CMD_ER_PAGE: op_kind = OP_ER_PAGE;
      CMD_ER_4K: op_kind = OP_ER_4K;
      CMD_ER_32K: op_kind = OP_ER_32K;
      CMD_ER_64K: op_kind = OP_ER_64K;
      CMD_ER_CHIP: op_kind = OP_ER_CHIP;
      default: op_kind = OP_PROG;
    endcase
  endfunction

  // Array address aligned to the erase size
  function automatic logic [ADDR_BITS-1:0] op_mask(input logic [7:0] c);
    case (c)
      CMD_ER_4K: op_mask = MASK_4K;
      CMD_ER_32K: op_mask = MASK_32K;
      CMD_ER_64K: op_mask = MASK_64K;
      CMD_ER_CHIP: op_mask = MASK_CHIP;
      default: op_mask = MASK_PAGE;
    endcase
  endfunction

  // Top address bit picks the OTP areas over the page buffer
  function automatic logic [MEM_AW-1:0] rd_map(input logic [ADDR_BITS-1:0] a);
    rd_map = a[ADDR_BITS-1] ? (OTP_BASE | {1'b0, a[8:0]}) : {2'b00, a[7:0]};
  endfunction

  function automatic logic [MEM_AW-1:0] rd_next(input logic [MEM_AW-1:0] a);
    if (a[MEM_AW-1]) begin
      rd_next = {1'b1, 9'(a[8:0] + 9'h001)};
    end else begin
      rd_next = {2'b00, 8'(a[7:0] + 8'h01)};
    end
  endfunction

  // ************************************************
  // Buffer and OTP storage
  // ************************************************
  // Array owns the read port while its timed operation runs
  assign mem_ra = q.busy ? {2'b00, arr_buf_addr_i} : q.rd_addr;

  sfpi_mem #(
    .DW(MEM_DW),
    .AW(MEM_AW)
  ) u_mem (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(q.mem_we),
    .wa_i(q.mem_wa),
    .wd_i(q.mem_wd),
    .ra_i(mem_ra),
    .rd_o(mem_rd)
  );

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    next_q = q;
    next_q.op.valid = 1'b0;
    next_q.mem_we = 1'b0;
    next_q.sync1 = pins_i;
    next_q.sync2 = q.sync1;
    next_q.cs_d = q.sync2.cs_n;
    next_q.sck_d = q.sync2.sck;
    cs_fall = q.cs_d & ~q.sync2.cs_n;
    cs_rise = ~q.cs_d & q.sync2.cs_n;
    sck_rise = ~q.sck_d & q.sync2.sck & ~q.sync2.cs_n;
    sck_fall = q.sck_d & ~q.sync2.sck & ~q.sync2.cs_n;
    status = '0;
    status[STAT_BUSY] = q.busy;
    status[STAT_IRQ] = q.irq;
    status[STAT_DPD] = q.dpd;
    case (q.lanes)
      LANE_2: step = STEP_2;
      LANE_4: step = STEP_4;
      default: step = STEP_1;
    endcase
    src = (q.ocnt == 3'h0) ? ((q.cmd == CMD_STATUS) ? status : mem_rd) : q.shout;
    if (op_done_i) begin
      next_q.busy = 1'b0;
    end
    if (q.sync2.cs_n) begin
      next_q.drv.oe = 4'h0;
    end
    if (cs_fall) begin
      next_q.phase = PH_CMD;
      next_q.cnt = 5'h00;
      next_q.ocnt = 3'h0;
      next_q.pend = 1'b0;
    end else if (cs_rise) begin
      next_q.phase = PH_IGNORE;
      next_q.pend = 1'b0;
      if (q.pend) begin
        case (q.cmd)
          CMD_DPD: next_q.dpd = 1'b1;
          CMD_OTP_LOCK: next_q.locks[q.addr[8:7]] = 1'b1;
          default: begin
            next_q.op.valid = 1'b1;
            next_q.op.kind = op_kind(q.cmd);
            next_q.op.addr = q.addr & op_mask(q.cmd);
            next_q.busy = 1'b1;
          end
        endcase
      end
    end else if (sck_rise) begin
      next_q.shin = {q.shin[6:0], q.sync2.io[0]};
      next_q.cnt = 5'(q.cnt + 5'h01);
      case (q.phase)
        PH_CMD: begin
          if (q.cnt == BYTE_LAST) begin
            next_q.cmd = next_q.shin;
            next_q.cnt = 5'h00;
            next_q.phase = PH_IGNORE;
            next_q.rd = 1'b0;
            // Deep sleep only listens for resume; busy only for status
            if (q.dpd) begin
              if (next_q.shin == CMD_RESUME) begin
                next_q.dpd = 1'b0;
              end
            end else if (!q.busy || next_q.shin == CMD_STATUS) begin
              case (next_q.shin)
                CMD_STATUS: begin
                  next_q.phase = PH_XFER;
                  next_q.lanes = LANE_1;
                  next_q.rd = 1'b1;
                  next_q.irq = 1'b0;
                end
                CMD_DPD, CMD_ER_CHIP: next_q.pend = 1'b1;
                CMD_READ, CMD_DUAL, CMD_QUAD, CMD_BUF_WR, CMD_PROG, CMD_ER_PAGE, CMD_ER_4K,
                CMD_ER_32K, CMD_ER_64K, CMD_OTP_WR, CMD_OTP_LOCK: next_q.phase = PH_ADDR;
                default: next_q.phase = PH_IGNORE;
              endcase
            end
          end
        end
        PH_ADDR: begin
          next_q.addr = {q.addr[ADDR_BITS-2:0], q.sync2.io[0]};
          if (q.cnt == ADDR_LAST) begin
            next_q.cnt = 5'h00;
            next_q.rd_addr = rd_map(next_q.addr);
            case (q.cmd)
              CMD_READ: begin
                next_q.phase = PH_XFER;
                next_q.lanes = LANE_1;
                next_q.rd = 1'b1;
              end
              CMD_DUAL, CMD_QUAD: begin
                next_q.phase = PH_DUMMY;
                next_q.lanes = (q.cmd == CMD_QUAD) ? LANE_4 : LANE_2;
                next_q.rd = 1'b1;
              end
              CMD_BUF_WR, CMD_OTP_WR: next_q.phase = PH_XFER;
              default: begin
                next_q.phase = PH_IGNORE;
                next_q.pend = 1'b1;
              end
            endcase
          end
        end
        PH_DUMMY: begin
          if (q.cnt == DUMMY_LAST) begin
            next_q.phase = PH_XFER;
            next_q.cnt = 5'h00;
          end
        end
        PH_XFER: begin
          // Write bytes land once all eight bits are in
          if (!q.rd && q.cnt == BYTE_LAST) begin
            next_q.cnt = 5'h00;
            next_q.mem_wd = next_q.shin;
            if (q.cmd == CMD_BUF_WR) begin
              next_q.mem_we = 1'b1;
              next_q.mem_wa = {2'b00, q.addr[7:0]};
              next_q.addr[7:0] = 8'(q.addr[7:0] + 8'h01);
            end else begin
              next_q.mem_we = ~q.locks[q.addr[8:7]];
              next_q.mem_wa = OTP_BASE | {1'b0, q.addr[8:0]};
              next_q.addr[6:0] = 7'(q.addr[6:0] + 7'h01);
            end
          end
        end
        default: next_q.phase = PH_IGNORE;
      endcase
    end else if (sck_fall && q.phase == PH_XFER && q.rd) begin
      case (q.lanes)
        LANE_2: begin
          next_q.drv.out = {2'b00, src[7:6]};
          next_q.drv.oe = 4'h3;
        end
        LANE_4: begin
          next_q.drv.out = src[7:4];
          next_q.drv.oe = 4'hF;
        end
        default: begin
          next_q.drv.out = {2'b00, src[7], 1'b0};
          next_q.drv.oe = 4'h2;
        end
      endcase
      next_q.shout = src << step;
      next_q.ocnt = 3'(q.ocnt + step);
      // Prefetch: the next byte is read long before it is needed
      if (q.ocnt == 3'h0) begin
        next_q.rd_addr = rd_next(q.rd_addr);
      end
    end
    // Completion wins over a status read clearing the flag
    if (op_done_i) begin
      next_q.irq = 1'b1;
    end
    if (next_q.dpd) begin
      next_q.pwr = PWR_DEEP;
    end else if (next_q.busy || !q.sync2.cs_n) begin
      next_q.pwr = PWR_ACTIVE;
    end else begin
      next_q.pwr = PWR_STANDBY;
    end
  end

  // ************************************************
  // State register
  // ************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.sync1.cs_n <= RST_CS_N;
      q.sync2.cs_n <= RST_CS_N;
      q.cs_d <= RST_CS_N;
    end else begin
      q <= next_q;
    end
  end

  assign drive_o = q.drv;
  assign op_o = q.op;
  assign arr_buf_data_o = mem_rd;
  assign irq_o = q.irq;
  assign pwr_o = q.pwr;
endmodule
`default_nettype wire

// file: sfpi_front_properties.sv
// Port checker of the serial flash pin front end.
// Assumes binding into sfpi_front, one core clock domain.
`timescale 1ns/10ps
`default_nettype none
module sfpi_front_properties (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire sfpi_pkg::sfpi_pins_s pins_i,
  input wire sfpi_pkg::sfpi_drive_s drive_o,
  input wire sfpi_pkg::sfpi_op_s op_o,
  input wire logic op_done_i,
  input wire logic irq_o,
  input wire sfpi_pkg::sfpi_pwr_e pwr_o
);
  import sfpi_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ******************
  // Pin and op rules
  // ******************
  oe_release_a: assert property ($rose(pins_i.cs_n) |-> ##[1:5] drive_o.oe == 4'h0)
    else $error("lines driven after deselect");
  lane_set_a: assert property (drive_o.oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("bad lane enables");
  out_on_fall_a: assert property ($changed(drive_o.out) && drive_o.oe != 4'h0 |-> !$past(pins_i.sck, 2))
    else $error("output moved off a falling clock");
  op_desel_a: assert property (op_o.valid |-> pins_i.cs_n && $past(pins_i.cs_n, 3))
    else $error("op issued while selected");
  op_pulse_a: assert property (op_o.valid |=> !op_o.valid)
    else $error("op pulse too long");
  busy_active_a: assert property (op_o.valid && !op_done_i |=> pwr_o == PWR_ACTIVE)
    else $error("not active while busy");
  irq_set_a: assert property (op_done_i |=> irq_o)
    else $error("no interrupt after completion");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(op_done_i))
    else $error("interrupt without completion");
  standby_after_a: assert property (pins_i.cs_n [*4] ##0 (op_done_i && pwr_o == PWR_ACTIVE)
    |=> pwr_o == PWR_STANDBY)
    else $error("no standby after completion");
endmodule
bind sfpi_front sfpi_front_properties sfpi_front_properties_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .pins_i(pins_i), .drive_o(drive_o), .op_o(op_o), .op_done_i(op_done_i), .irq_o(irq_o), .pwr_o(pwr_o));
`default_nettype wire

// file: sfpi_host.sv
// Host controller model: select, link clock and data lines.
// Assumes callers run at core clock falling edges; one bit takes 8 cycles.
`timescale 1ns/10ps
`default_nettype none
module sfpi_host (
  input wire logic core_clk_i,
  input wire sfpi_pkg::sfpi_drive_s drive_i,
  output sfpi_pkg::sfpi_pins_s pins_o,
  output logic [7:0] rx_o,
  output logic [7:0] rx_cnt_o
);
  import sfpi_pkg::*;
  logic cs_n = 1'b1;
  logic sck = 1'b0;
  logic m3 = 1'b0;
  logic tgl = 1'b0;
  logic [3:0] hval = 4'h0;
  logic [3:0] hoe = 4'h1;
  initial begin
    rx_o = 8'h00;
    rx_cnt_o = 8'h00;
  end
  // ******************
  // Wire levels
  // ******************
  // Free lines: upper two pulled up, lower two keep changing
  always @(negedge core_clk_i) tgl <= ~tgl;
  assign pins_o = {cs_n, sck, (drive_i.oe & drive_i.out) | (~drive_i.oe & hoe & hval)
    | (~drive_i.oe & ~hoe & {2'b11, tgl, ~tgl})};
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Idle clock level picks mode 0 or 3
  task automatic start(input logic mode3);
    m3 = mode3;
    sck = mode3;
    cyc(4);
    cs_n = 1'b0;
    cyc(4);
  endtask
  task automatic stop();
    if (!m3) begin
      sck = 1'b0;
      cyc(4);
    end
    cs_n = 1'b1;
    hoe = 4'h1;
    cyc(6);
  endtask
  // Fall launches, lines sampled just before the rise
  task automatic step(input logic v, output logic [3:0] got);
    sck = 1'b0;
    hval = {3'b000, v};
    cyc(5);
    got = pins_o.io;
    sck = 1'b1;
    cyc(3);
  endtask
  task automatic send(input logic [31:0] v, input int n);
    logic [3:0] g;
    for (int i = n - 1; i >= 0; i--) step(v[i], g);
  endtask
  task automatic read(input int nb, input int ln, input int dm);
    logic [3:0] g;
    logic [7:0] acc;
    if (ln > 1) hoe = 4'h0;
    repeat (dm) step(1'b0, g);
    repeat (nb) begin
      acc = 8'h00;
      repeat (8 / ln) begin
        step(1'b0, g);
        acc = ln == 1 ? {acc[6:0], g[1]} : ln == 2 ? {acc[5:0], g[1:0]} : {acc[3:0], g};
      end
      rx_o = acc;
      rx_cnt_o = rx_cnt_o + 8'h01;
    end
  endtask
endmodule
`default_nettype wire

// file: sfpi_mem.sv
// Byte memory holding the page buffer and the OTP areas.
// Assumes one writer and one reader on the core clock.
`timescale 1ns/10ps
`default_nettype none
module sfpi_mem #(
  parameter int unsigned DW = 8,
  parameter int unsigned AW = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] wa_i,
  input wire logic [DW-1:0] wd_i,
  input wire logic [AW-1:0] ra_i,
  output logic [DW-1:0] rd_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array; contents are undefined until written
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[wa_i] <= wd_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_o <= '0;
    end else begin
      rd_o <= mem[ra_i];
    end
  end
endmodule
`default_nettype wire

// file: sfpi_pkg.sv
// Shared constants and types of the serial flash pin front end.
// Assumes one core clock; the pins arrive unsynchronised.
package sfpi_pkg;

  // ************************************************
  // Sizes and counts
  // ************************************************
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned MEM_AW = 10;
  localparam int unsigned MEM_DW = 8;
  localparam int unsigned DUMMY_CLKS = 8;
  localparam logic [4:0] ADDR_LAST = 5'(ADDR_BITS - 1);
  localparam logic [4:0] DUMMY_LAST = 5'(DUMMY_CLKS - 1);
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [2:0] STEP_1 = 3'h1;
  localparam logic [2:0] STEP_2 = 3'h2;
  localparam logic [2:0] STEP_4 = 3'h4;

  // ************************************************
  // Memory map: page buffer low, four OTP areas high
  // ************************************************
  localparam logic [MEM_AW-1:0] OTP_BASE = 10'h200;
  localparam logic [ADDR_BITS-1:0] MASK_PAGE = 24'hFFFF00;
  localparam logic [ADDR_BITS-1:0] MASK_4K = 24'hFFF000;
  localparam logic [ADDR_BITS-1:0] MASK_32K = 24'hFF8000;
  localparam logic [ADDR_BITS-1:0] MASK_64K = 24'hFF0000;
  localparam logic [ADDR_BITS-1:0] MASK_CHIP = 24'h000000;

  // ************************************************
  // Opcodes
  // ************************************************
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_DUAL = 8'h3B;
  localparam logic [7:0] CMD_QUAD = 8'h6B;
  localparam logic [7:0] CMD_STATUS = 8'h05;
  localparam logic [7:0] CMD_BUF_WR = 8'h84;
  localparam logic [7:0] CMD_PROG = 8'h88;
  localparam logic [7:0] CMD_ER_PAGE = 8'h81;
  localparam logic [7:0] CMD_ER_4K = 8'h20;
  localparam logic [7:0] CMD_ER_32K = 8'h52;
  localparam logic [7:0] CMD_ER_64K = 8'hD8;
  localparam logic [7:0] CMD_ER_CHIP = 8'h60;
  localparam logic [7:0] CMD_OTP_WR = 8'h9B;
  localparam logic [7:0] CMD_OTP_LOCK = 8'h9C;
  localparam logic [7:0] CMD_DPD = 8'hB9;
  localparam logic [7:0] CMD_RESUME = 8'hAB;

  // Status byte bit positions
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_IRQ = 1;
  localparam int unsigned STAT_DPD = 2;

  // Values after reset
  localparam logic RST_CS_N = 1'b1;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b011,
    PH_XFER = 3'b010,
    PH_IGNORE = 3'b110
  } sfpi_phase_e;

  typedef enum logic [1:0] {
    LANE_1 = 2'b00,
    LANE_2 = 2'b01,
    LANE_4 = 2'b11
  } sfpi_lane_e;

  typedef enum logic [2:0] {
    OP_PROG = 3'h0,
    OP_ER_PAGE = 3'h1,
    OP_ER_4K = 3'h2,
    OP_ER_32K = 3'h3,
    OP_ER_64K = 3'h4,
    OP_ER_CHIP = 3'h5
  } sfpi_op_e;

  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_ACTIVE = 2'b01,
    PWR_DEEP = 2'b11
  } sfpi_pwr_e;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [3:0] io;
  } sfpi_pins_s;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sfpi_drive_s;

  typedef struct packed {
    logic valid;
    sfpi_op_e kind;
    logic [ADDR_BITS-1:0] addr;
  } sfpi_op_s;

  typedef struct packed {
    sfpi_pins_s sync1;
    sfpi_pins_s sync2;
    logic cs_d;
    logic sck_d;
    sfpi_phase_e phase;
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [7:0] shin;
    logic [7:0] shout;
    logic [ADDR_BITS-1:0] addr;
    logic [2:0] ocnt;
    sfpi_lane_e lanes;
    logic rd;
    logic pend;
    logic busy;
    logic irq;
    logic dpd;
    logic [3:0] locks;
    logic [MEM_AW-1:0] rd_addr;
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [MEM_DW-1:0] mem_wd;
    sfpi_drive_s drv;
    sfpi_op_s op;
    sfpi_pwr_e pwr;
  } sfpi_state_s;

endpackage
